// ===== pkg/etc_pkg.sv
// edge_timing_control package: register map, field positions, types.
// assumes one 25 MHz clock, APB4 slave with 32-bit data.
//
// How it works
// - edge1 flag set by event, writable
// - sense mode bit: edge or level
// - polarity bit: rising or falling response
// - source codes 15..12: comparators, bus clock
// - codes 11..2: captures and edge pins
// - code 1 compare event, 0 timer
// - bits 17:16 and 14 read zero
// - unit runs only while enabled
// - idle-stop bit halts unit in idle
// - delay generation bit enables delay output
// - clearing the edge gate bit blocks all edges
// - discharge bit connects capacitor sink
package etc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam int            ADDR_W            = 12;
   localparam logic [11:0]   OFS_CONTROL       = 12'h000;
   localparam logic [31:0]   CONTROL_RESET     = 32'h0000_0000;

   // field positions inside charge_unit_control
   localparam int            POS_EDGE1_SEEN    = 24;
   localparam int            POS_SENSE_MODE    = 23;
   localparam int            POS_POLARITY      = 22;
   localparam int            POS_SRC_HI        = 21;
   localparam int            POS_SRC_LO        = 18;
   localparam int            POS_ENABLE        = 15;
   localparam int            POS_IDLE_STOP     = 13;
   localparam int            POS_DELAY_GEN     = 12;
   localparam int            POS_EDGE_GATE     = 11;
   localparam int            POS_DISCHARGE     = 9;

   ////////////////////////////////////////////////////////////////////////
   // edge2 source codes
   localparam int            NUM_SRC           = 16;
   localparam int            SYNC_STAGES       = 2;
   localparam logic [3:0]    SRC_CMP3          = 4'hF;
   localparam logic [3:0]    SRC_CMP2          = 4'hE;
   localparam logic [3:0]    SRC_CMP1          = 4'hD;
   localparam logic [3:0]    SRC_BUS_CLOCK     = 4'hC;
   localparam logic [3:0]    SRC_CAP3          = 4'hB;
   localparam logic [3:0]    SRC_CAP2          = 4'hA;
   localparam logic [3:0]    SRC_CAP1          = 4'h9;
   localparam logic [3:0]    SRC_PIN13         = 4'h8;
   localparam logic [3:0]    SRC_PIN12         = 4'h7;
   localparam logic [3:0]    SRC_PIN11         = 4'h6;
   localparam logic [3:0]    SRC_PIN10         = 4'h5;
   localparam logic [3:0]    SRC_PIN9          = 4'h4;
   localparam logic [3:0]    SRC_PIN1          = 4'h3;
   localparam logic [3:0]    SRC_PIN2          = 4'h2;
   localparam logic [3:0]    SRC_COMPARE1      = 4'h1;
   localparam logic [3:0]    SRC_TIMER_ONE     = 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef struct packed {
      logic       edge1_seen_flag;
      logic       edge2_sense_mode;
      logic       edge2_polarity;
      logic [3:0] edge2_source_sel;
      logic       enable;
      logic       idle_stop;
      logic       delay_gen_enable;
      logic       edge_gate_enable;
      logic       sample_cap_discharge;
   } etc_ctl_t;

   typedef struct packed {
      logic       charge_on;
      logic       delay_out;
      logic       discharge_on;
      logic       edge1_level;
      logic       edge2_event;
      logic       edge2_active;
      logic       unit_running;
   } etc_out_t;

endpackage

// ===== rtl/etc_sync.sv
// etc_sync: two-flop synchroniser for a vector of asynchronous levels.
// assumes inputs come from pins or other clock domains.
`timescale 1ns/1ps
module etc_sync #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   import etc_pkg::*;

   logic [W-1:0] stage_one;

   ////////////////////////////////////////////////////////////////////////
   // first flop feeds only the second
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               stage_one[g] <= 1'b0;
               sync_out[g]  <= 1'b0;
            end else begin
               stage_one[g] <= async_in[g];
               sync_out[g]  <= stage_one[g];
            end
         end
      end
   endgenerate

endmodule // etc_sync

// ===== rtl/etc_edge_det.sv
// etc_edge_det: polarity-selectable edge and level detector.
// assumes a synchronised input on clk_sys.
`timescale 1ns/1ps
module etc_edge_det (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // control
   input  wire logic polarity,
   input  wire logic edge_mode,
   // signal in, detection out
   input  wire logic sig_in,
   output logic      hit,
   output logic      level_match
);
   import etc_pkg::*;

   logic prev;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prev <= 1'b0;
      end else begin
         prev <= sig_in;
      end
   end

   // level mode: active while input sits at the chosen level
   assign level_match = (sig_in == polarity);
   assign hit = edge_mode ?
                (polarity ? (sig_in & ~prev) : (~sig_in & prev))
                : level_match;

endmodule // etc_edge_det

// ===== rtl/etc_top.sv
// etc_top: edge control of the charge-time measurement unit.
// assumes APB4 master on clk_sys; event sources are asynchronous to it.
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module etc_top (
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      rst,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [etc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // chip power state
   input  wire logic                      chip_idle,
   // edge1 source
   input  wire logic                      edge1_src,
   // edge2 candidate sources
   input  wire logic                      comparator_one_output,
   input  wire logic                      comparator_two_output,
   input  wire logic                      comparator_three_output,
   input  wire logic [3:1]                capture_event,
   input  wire logic                      ext_edge_pin_one,
   input  wire logic                      ext_edge_pin_two,
   input  wire logic [13:9]               ext_edge_pin_hi,
   input  wire logic                      compare_unit_one,
   input  wire logic                      timer_one,
   // unit outputs
   output etc_pkg::etc_out_t              unit_out
);
   import etc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations
   etc_ctl_t          ctl;
   logic [31:0]       next_prdata;
   logic              bus_setup;
   logic              bus_write;
   logic              addr_hit;
   logic [31:0]       wmask;
   logic [31:0]       wval;
   logic [NUM_SRC-1:0] src_raw;
   logic [NUM_SRC-1:0] src_sync;
   logic              edge1_raw;
   logic              edge1_sync;
   logic              edge1_prev;
   logic              edge1_event;
   logic              bus_clock_level;
   logic              run;
   logic              edges_open;
   logic              edge2_sel;
   logic              edge2_hit;
   logic              edge2_level;
   logic              next_edge1_flag;
   logic              sw_flag_write;

   ////////////////////////////////////////////////////////////////////////
   // register bus decode
   function automatic logic is_control(input logic [ADDR_W-1:0] a);
      return a == OFS_CONTROL;
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[i*8 +: 8] = 8'hFF;
         end
      end
      return m;
   endfunction

   assign bus_setup = psel & ~penable;
   assign addr_hit  = is_control(paddr);
   assign bus_write = psel & penable & pwrite & addr_hit;
   assign wmask     = lane_mask(pstrb);
   assign wval      = pwdata & wmask;

   // zero wait state: data registered in setup, answered in access
   assign pready  = psel & penable;
   assign pslverr = psel & penable & ~addr_hit;

   ////////////////////////////////////////////////////////////////////////
   // control register fields
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctl.edge2_sense_mode     <= CONTROL_RESET[POS_SENSE_MODE];
         ctl.edge2_polarity       <= CONTROL_RESET[POS_POLARITY];
         ctl.edge2_source_sel     <= CONTROL_RESET[POS_SRC_HI:POS_SRC_LO];
         ctl.enable               <= CONTROL_RESET[POS_ENABLE];
         ctl.idle_stop            <= CONTROL_RESET[POS_IDLE_STOP];
         ctl.delay_gen_enable     <= CONTROL_RESET[POS_DELAY_GEN];
         ctl.edge_gate_enable     <= CONTROL_RESET[POS_EDGE_GATE];
         ctl.sample_cap_discharge <= CONTROL_RESET[POS_DISCHARGE];
      end else if (bus_write) begin
         if (wmask[POS_SENSE_MODE]) begin
            ctl.edge2_sense_mode <= wval[POS_SENSE_MODE];
         end
         if (wmask[POS_POLARITY]) begin
            ctl.edge2_polarity <= wval[POS_POLARITY];
         end
         if (wmask[POS_SRC_HI]) begin
            ctl.edge2_source_sel <= wval[POS_SRC_HI:POS_SRC_LO];
         end
         if (wmask[POS_ENABLE]) begin
            ctl.enable <= wval[POS_ENABLE];
         end
         if (wmask[POS_IDLE_STOP]) begin
            ctl.idle_stop <= wval[POS_IDLE_STOP];
         end
         if (wmask[POS_DELAY_GEN]) begin
            ctl.delay_gen_enable <= wval[POS_DELAY_GEN];
         end
         if (wmask[POS_EDGE_GATE]) begin
            ctl.edge_gate_enable <= wval[POS_EDGE_GATE];
         end
         if (wmask[POS_DISCHARGE]) begin
            ctl.sample_cap_discharge <= wval[POS_DISCHARGE];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // edge1 status flag
   // software writes drive the flag directly; a hardware event in the
   // same cycle as a written zero still sets it
   assign sw_flag_write = bus_write & wmask[POS_EDGE1_SEEN];

   always_comb begin
      next_edge1_flag = ctl.edge1_seen_flag;
      if (sw_flag_write) begin
         next_edge1_flag = wval[POS_EDGE1_SEEN];
      end
      if (edge1_event) begin
         next_edge1_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctl.edge1_seen_flag <= CONTROL_RESET[POS_EDGE1_SEEN];
      end else begin
         ctl.edge1_seen_flag <= next_edge1_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, registered in the setup cycle
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_prdata[POS_EDGE1_SEEN]        = ctl.edge1_seen_flag;
      next_prdata[POS_SENSE_MODE]        = ctl.edge2_sense_mode;
      next_prdata[POS_POLARITY]          = ctl.edge2_polarity;
      next_prdata[POS_SRC_HI:POS_SRC_LO] = ctl.edge2_source_sel;
      next_prdata[POS_ENABLE]            = ctl.enable;
      next_prdata[POS_IDLE_STOP]         = ctl.idle_stop;
      next_prdata[POS_DELAY_GEN]         = ctl.delay_gen_enable;
      next_prdata[POS_EDGE_GATE]         = ctl.edge_gate_enable;
      next_prdata[POS_DISCHARGE]         = ctl.sample_cap_discharge;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (bus_setup) begin
         prdata <= (addr_hit & ~pwrite) ? next_prdata : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // run state
   // idle only halts when the stop bit asks for it
   assign run        = ctl.enable & ~(ctl.idle_stop & chip_idle);
   assign edges_open = run & ctl.edge_gate_enable;

   ////////////////////////////////////////////////////////////////////////
   // bus clock as a source: a divide-by-two toggle stands for the
   // clock itself, since a flop cannot sample its own clock
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bus_clock_level <= 1'b0;
      end else begin
         bus_clock_level <= ~bus_clock_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // source vector, indexed by code
   always_comb begin
      src_raw                = '0;
      src_raw[SRC_CMP3]      = comparator_three_output;
      src_raw[SRC_CMP2]      = comparator_two_output;
      src_raw[SRC_CMP1]      = comparator_one_output;
      src_raw[SRC_CAP3]      = capture_event[3];
      src_raw[SRC_CAP2]      = capture_event[2];
      src_raw[SRC_CAP1]      = capture_event[1];
      src_raw[SRC_PIN13]     = ext_edge_pin_hi[13];
      src_raw[SRC_PIN12]     = ext_edge_pin_hi[12];
      src_raw[SRC_PIN11]     = ext_edge_pin_hi[11];
      src_raw[SRC_PIN10]     = ext_edge_pin_hi[10];
      src_raw[SRC_PIN9]      = ext_edge_pin_hi[9];
      src_raw[SRC_PIN1]      = ext_edge_pin_one;
      src_raw[SRC_PIN2]      = ext_edge_pin_two;
      src_raw[SRC_COMPARE1]  = compare_unit_one;
      src_raw[SRC_TIMER_ONE] = timer_one;
   end

   // every source except the bus clock toggle crosses before the mux, so a change of the
   // select never exposes an unsynchronised level
   etc_sync #(
      .W (NUM_SRC)
   ) u_src_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in (src_raw),
      .sync_out (src_sync)
   );

   assign edge1_raw = edge1_src;

   etc_sync #(
      .W (1)
   ) u_edge1_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .async_in (edge1_raw),
      .sync_out (edge1_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // edge2 selection and detection
   always_comb begin
      edge2_sel = src_sync[ctl.edge2_source_sel];
      if (ctl.edge2_source_sel == SRC_BUS_CLOCK) begin
         edge2_sel = bus_clock_level;
      end
   end

   etc_edge_det u_edge2_det (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .polarity    (ctl.edge2_polarity),
      .edge_mode   (ctl.edge2_sense_mode),
      .sig_in      (edge2_sel),
      .hit         (edge2_hit),
      .level_match (edge2_level)
   );

   ////////////////////////////////////////////////////////////////////////
   // edge1 rising-edge detection
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         edge1_prev <= 1'b0;
      end else begin
         edge1_prev <= edge1_sync;
      end
   end

   assign edge1_event = edges_open & edge1_sync & ~edge1_prev;

   ////////////////////////////////////////////////////////////////////////
   // outputs, all registered
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         unit_out <= '0;
      end else begin
         unit_out.unit_running <= run;
         unit_out.edge1_level  <= next_edge1_flag & run;
         unit_out.edge2_event  <= edges_open & edge2_hit
                                  & ctl.edge2_sense_mode;
         unit_out.edge2_active <= edges_open & edge2_hit;
         // charge runs while the unit runs and the edge1 flag is set, except in cycles where edge2 hits while edges are open
         unit_out.charge_on    <= run & next_edge1_flag
                                  & ~(edges_open & edge2_hit);
         // pulse delay expects comparator two as stop source
         unit_out.delay_out    <= run & ctl.delay_gen_enable
                                  & next_edge1_flag
                                  & ~(edges_open & edge2_hit);
         // sink output follows the discharge bit alone, one cycle later
         unit_out.discharge_on <= ctl.sample_cap_discharge;
      end
   end

endmodule // etc_top

// ===== tb/etc_top_properties.sv
// etc_top_properties: port-level checks of etc_top, bound to it.
// assumes apb writes at offset zero are the only way into the control word.
`timescale 1ns/1ps
module etc_top_properties (
   // clock and reset
   input wire logic                       clk_sys,
   input wire logic                       rst,
   // apb slave
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [etc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [3:0]                 pstrb,
   input wire logic [31:0]                prdata,
   // power state and outputs
   input wire logic                       chip_idle,
   input wire etc_pkg::etc_out_t          unit_out
);
   import etc_pkg::*;
   // flag left out: hardware may set it at any time
   localparam logic [31:0] WMASK = 32'h00FC_BA00;
   logic [31:0] shadow;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shadow <= CONTROL_RESET;
      end else if (psel && penable && pwrite && paddr == OFS_CONTROL) begin
         for (int i = 0; i < 4; i++) begin
            if (pstrb[i]) begin
               shadow[8*i +: 8] <= pwdata[8*i +: 8] & WMASK[8*i +: 8];
            end
         end
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ///////////////////////////////////////////////////////////////////
   property p_rsvd_zero;
      psel && penable && !pwrite |-> prdata[17:16] == 2'h0 && !prdata[14];
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved control bits read nonzero");
   property p_off_stops;
      !shadow[POS_ENABLE] |=> !unit_out.unit_running
         && !unit_out.edge1_level && !unit_out.charge_on;
   endproperty
   a_off_stops: assert property (p_off_stops)
      else $error("unit active while disabled");
   property p_on_runs;
      shadow[POS_ENABLE] && !chip_idle |=> unit_out.unit_running;
   endproperty
   a_on_runs: assert property (p_on_runs)
      else $error("unit not running while enabled");
   property p_idle_halt;
      shadow[POS_ENABLE] && shadow[POS_IDLE_STOP] && chip_idle
         |=> !unit_out.unit_running;
   endproperty
   a_idle_halt: assert property (p_idle_halt)
      else $error("unit kept running in idle");
   property p_idle_keep;
      shadow[POS_ENABLE] && !shadow[POS_IDLE_STOP] |=> unit_out.unit_running;
   endproperty
   a_idle_keep: assert property (p_idle_keep)
      else $error("unit halted without idle stop");
   property p_discharge;
      unit_out.discharge_on == $past(shadow[POS_DISCHARGE]);
   endproperty
   a_discharge: assert property (p_discharge)
      else $error("discharge output does not follow its bit");
   property p_delay_off;
      !shadow[POS_DELAY_GEN] && !$past(shadow[POS_DELAY_GEN])
         |-> !unit_out.delay_out;
   endproperty
   a_delay_off: assert property (p_delay_off)
      else $error("delay output while delay generation off");
   property p_gate_block;
      !shadow[POS_EDGE_GATE] && !$past(shadow[POS_EDGE_GATE])
         && !$past(shadow[POS_EDGE_GATE], 2) |-> !unit_out.edge2_event;
   endproperty
   a_gate_block: assert property (p_gate_block)
      else $error("edge passed while edges blocked");
   property p_level_quiet;
      unit_out.edge2_event |-> $past(shadow[POS_SENSE_MODE]);
   endproperty
   a_level_quiet: assert property (p_level_quiet)
      else $error("edge pulse in level mode");
endmodule // etc_top_properties

bind etc_top etc_top_properties u_props (
   .clk_sys   (clk_sys),
   .rst       (rst),
   .psel      (psel),
   .penable   (penable),
   .pwrite    (pwrite),
   .paddr     (paddr),
   .pwdata    (pwdata),
   .pstrb     (pstrb),
   .prdata    (prdata),
   .chip_idle (chip_idle),
   .unit_out  (unit_out)
);

// ===== tb/etc_src_model.sv
// etc_src_model: on-chip event sources seen by the edge control block.
// assumes bit n of ev is the source of edge2 code n; bit 12 is unused.
`timescale 1ns/1ps
module etc_src_model (
   // clock
   input wire logic clk_sys,
   // event sources
   output logic [15:0] ev,
   output logic        edge1
);
   initial begin
      ev = 16'h0000;
      edge1 = 1'b0;
   end
   // held two cycles so the two-flop synchroniser cannot miss it
   task automatic drive(input logic [15:0] v, input logic e1);
      @(posedge clk_sys);
      ev <= v;
      edge1 <= e1;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule // etc_src_model

// ===== tb/etc_top_tb.sv
// etc_top_tb: self-checking bench for etc_top with an apb master.
// assumes etc_src_model stands for the event sources.
`timescale 1ns/1ps
module etc_top_tb;
   import etc_pkg::*;
   localparam logic [31:0] WMASK = 32'h01FC_BA00;
   logic              clk_sys, rst, psel, penable, pwrite;
   logic              pready, pslverr, chip_idle, edge1, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0]       pwdata, prdata, rd, ctl, d;
   logic [3:0]        pstrb, s;
   logic [15:0]       ev, idle;
   etc_out_t          uo;
   int                mismatches, checked, hits, h0, nb;
   initial clk_sys = 1'b0;
   always #20 clk_sys = ~clk_sys;
   etc_src_model model (.clk_sys(clk_sys), .ev(ev), .edge1(edge1));
   etc_top dut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chip_idle(chip_idle), .edge1_src(edge1),
      .comparator_one_output(ev[13]), .comparator_two_output(ev[14]),
      .comparator_three_output(ev[15]), .capture_event(ev[11:9]),
      .ext_edge_pin_one(ev[3]), .ext_edge_pin_two(ev[2]),
      .ext_edge_pin_hi(ev[8:4]), .compare_unit_one(ev[1]),
      .timer_one(ev[0]), .unit_out(uo));
   always @(posedge clk_sys) if (uo.edge2_event === 1'b1) hits++;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] wd, input logic [3:0] st);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pstrb <= st;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      // only the watchdog ends a wait for the answer
      while (pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic pulses(input logic [15:0] v, input int exp);
      h0 = hits;
      model.drive(v, 1'b0);
      settle(8);
      check(hits - h0, exp);
   endtask
   function automatic logic [31:0] merge(input logic [31:0] o, w,
                                         input logic [3:0] st);
      for (int i = 0; i < 4; i++) if (st[i]) o[8*i +: 8] = w[8*i +: 8];
      return o & WMASK;
   endfunction
   function automatic logic [31:0] cfg(input logic [3:0] c,
                                       input logic p, input logic m);
      return {8'h00, m, p, c, 18'h0} | 32'h0000_8800;
   endfunction
   initial begin
      repeat (10000) @(posedge clk_sys);
      mismatches++;
      give_verdict();
   end
   ///////////////////////////////////////////////////////////////////
   initial begin
      {rst, psel, penable, pwrite, chip_idle} = 5'h10;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      void'($urandom(32'hDCFAFF56));
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, OFS_CONTROL, 32'h0, 4'h0);
      check(rd, CONTROL_RESET);
      ctl = CONTROL_RESET;
      for (int i = 0; i < 12; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         s = (i == 0) ? 4'hF : 4'($urandom);
         apb(1'b1, OFS_CONTROL, d, s);
         ctl = merge(ctl, d, s);
         apb(1'b0, OFS_CONTROL, 32'h0, 4'h0);
         check(rd, ctl);
      end
      // unmapped word refused, control word untouched
      apb(1'b1, 12'h004, 32'hFFFF_FFFF, 4'hF);
      check({31'h0, err}, 32'h1);
      apb(1'b0, 12'h004, 32'h0, 4'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b0, OFS_CONTROL, 32'h0, 4'h0);
      check(rd, ctl);
      apb(1'b1, OFS_CONTROL, cfg(4'h3, 1'b1, 1'b1), 4'hF);
      model.drive(16'h0000, 1'b1);
      settle(3);
      check(uo.edge1_level, 1'b1);
      apb(1'b0, OFS_CONTROL, 32'h0, 4'h0);
      check(rd[POS_EDGE1_SEEN], 1'b1);
      apb(1'b1, OFS_CONTROL, 32'h0, 4'h8);
      apb(1'b0, OFS_CONTROL, 32'h0, 4'h0);
      check(rd[POS_EDGE1_SEEN], 1'b0);
      model.drive(16'h0000, 1'b0);
      for (int p = 0; p < 2; p++) for (int c = 0; c < 16; c++) begin
         if (c != 12) begin
            nb = (c == 11) ? 13 : (c + 1) % 16;
            idle = p ? 16'h0000 : 16'hFFFF;
            apb(1'b1, OFS_CONTROL, cfg(4'(c), 1'(p), 1'b1), 4'hF);
            model.drive(idle, 1'b0);
            settle(4);
            pulses(idle ^ (16'h1 << nb), 0);
            pulses(idle ^ (16'h1 << nb) ^ (16'h1 << c), 1);
            pulses(idle, 0);
         end
      end
      apb(1'b1, OFS_CONTROL, cfg(4'hC, 1'b1, 1'b1), 4'hF);
      settle(4);
      h0 = hits;
      settle(20);
      check(hits - h0 >= 9 && hits - h0 <= 11, 1'b1);
      apb(1'b1, OFS_CONTROL, cfg(4'h3, 1'b1, 1'b0), 4'hF);
      for (int k = 1; k >= 0; k--) begin
         model.drive(16'h0008 * 16'(k), 1'b0);
         settle(4);
         check({uo.edge2_active, uo.edge2_event}, {1'(k), 1'b0});
      end
      for (int g = 0; g < 2; g++) begin
         apb(1'b1, OFS_CONTROL, cfg(4'h3, 1'b1, 1'b1) & (g ? 32'hFFFF_7FFF
            : 32'hFFFF_F7FF), 4'hF);
         settle(4);
         pulses(16'h0008, 0);
         pulses(16'h0000, 0);
         check(uo.unit_running, 1'(!g));
      end
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, OFS_CONTROL, cfg(4'h3, 1'b1, 1'b1) | 32'(k) << 13, 4'hF);
         chip_idle <= 1'b1;
         settle(3);
         check(uo.unit_running, 1'(!k));
         chip_idle <= 1'b0;
      end
      // pulse delay takes comparator two as edge2 source
      apb(1'b1, OFS_CONTROL, cfg(4'hE, 1'b1, 1'b1) | 32'h0100_1200,
         4'hF);
      settle(4);
      check({uo.charge_on, uo.delay_out}, 2'h3);
      // the converter is assumed held in sampling while discharging
      check(uo.discharge_on, 1'b1);
      apb(1'b1, OFS_CONTROL, cfg(4'hE, 1'b1, 1'b1) | 32'h0100_0000, 4'hF);
      settle(4);
      check({uo.charge_on, uo.delay_out, uo.discharge_on}, 3'h4);
      give_verdict();
   end
endmodule // etc_top_tb
